// ===== bench/clsp_exec_bench.sv
`timescale 1ns/1ps
`include "clsp_defines.vh"
module clsp_exec_bench;
  typedef struct packed {
    logic [3:0]  op;
    logic        m, bs;
    logic [15:0] od, a, b, x;
    logic        c;
  } clsp_row_t;
  reg         clk = 1'b0, rstn = 1'b0, start = 1'b0, m_flag = 1'b0, acc_b_sel = 1'b0, clr = 1'b0;
  reg         to_mem = 1'b0;
  reg  [3:0]  op_sel = 4'h0;
  reg  [7:0]  imm1 = 8'h00, imm2 = 8'h00;
  reg  [15:0] opnd = 16'h0000, direct_page_register = 16'h0100, mv_src = 16'h0000, mv_dst = 16'h0000, mv_cnt = 16'h0000;
  wire        mem_rd, mem_wr, busy, done, carry;
  wire [15:0] mem_addr, acc_a, acc_b, idx_x, idx_y, pc, sp, fw, lw;
  wire [7:0]  mem_wdata, mem_rdata, data_bank, nw;
  clsp_row_t  rows [0:9];
  integer     n_mismatch = 0, samples_checked = 0, i;
  logic [15:0] p;
  clsp_exec DUT (.clk(clk), .rstn(rstn), .start(start), .op_sel(op_sel), .m_flag(m_flag), .x_flag(1'b0),
    .acc_b_sel(acc_b_sel), .to_mem(to_mem), .imm1(imm1), .imm2(imm2), .instr_len(2'h1), .opnd(opnd),
    .ea(16'h0200), .mv_src(mv_src), .mv_dst(mv_dst), .mv_cnt(mv_cnt), .direct_page_register(direct_page_register), .mem_rdata(mem_rdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .done(done),
    .acc_a(acc_a), .acc_b(acc_b), .idx_x(idx_x), .idx_y(idx_y), .data_bank(data_bank), .pc(pc), .sp(sp),
    .carry(carry));
  clsp_mem_model u_mem (.clk(clk), .clr(clr), .rd(mem_rd), .wr(mem_wr), .addr(mem_addr), .wdata(mem_wdata),
    .rdata(mem_rdata), .first_wr(fw), .last_wr(lw), .n_wr(nw));
  always #50 clk = ~clk;
  task check(input logic [15:0] got, input logic [15:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        n_mismatch++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one start pulse, then a bounded wait for done sampled away from the edge
  task run_op(input [3:0] op, input m, input bs, input [15:0] od, input [7:0] i1, input [7:0] i2);
    integer k;
    begin
      @(posedge clk);
      {op_sel, m_flag, acc_b_sel, opnd, imm1, imm2} <= {op, m, bs, od, i1, i2};
      {start, clr} <= 2'b11;
      @(posedge clk);
      {start, clr} <= 2'b00;
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (done !== 1'b1 && k < 100);
      check({15'h0, done}, 16'h0001);
      check({15'h0, busy}, 16'h0000);
      // the last write strobe rides with done, so let the memory take it
      @(negedge clk);
    end
  endtask
  task summarize;
    begin
      $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // runs far past the roughly 110 cycles the tests need
  initial begin
    #300000;
    n_mismatch++;
    summarize;
  end
  initial begin
    rows[0] = '{4'h1, 1'b0, 1'b0, 16'h8421, 16'h8421, 16'h0000, 16'h0000, 1'b0};
    rows[1] = '{4'ha, 1'b0, 1'b0, 16'h1010, 16'h9431, 16'h0000, 16'h0000, 1'b0};
    rows[2] = '{4'h6, 1'b0, 1'b0, 16'h0000, 16'h4a18, 16'h0000, 16'h0000, 1'b1};
    rows[3] = '{4'h6, 1'b1, 1'b0, 16'h0000, 16'h4a0c, 16'h0000, 16'h0000, 1'b0};
    rows[4] = '{4'h7, 1'b0, 1'b0, 16'h0100, 16'h0c00, 16'h004a, 16'h0000, 1'b0};
    rows[5] = '{4'h1, 1'b1, 1'b1, 16'h12ff, 16'h0c00, 16'h00ff, 16'h0000, 1'b0};
    rows[6] = '{4'ha, 1'b1, 1'b0, 16'hff0f, 16'h0c0f, 16'h00ff, 16'h0000, 1'b0};
    rows[7] = '{4'h4, 1'b0, 1'b0, 16'h1234, 16'h0c0f, 16'h00ff, 16'h1234, 1'b0};
    rows[8] = '{4'h5, 1'b0, 1'b0, 16'h0abc, 16'h0c0f, 16'h00ff, 16'h1234, 1'b0};
    rows[9] = '{4'h7, 1'b1, 1'b0, 16'h0020, 16'h0ce0, 16'h0001, 16'h1234, 1'b0};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(sp, 16'h01ff);
    check(pc, 16'h0000);
    u_mem.mem[16'h0111] = 8'h3c;
    u_mem.mem[16'h0112] = 8'h4d;
    for (i = 0; i < 3; i++) u_mem.mem[16'h0300 + i] = 8'(i + 1);
    for (i = 0; i < 10; i++) begin
      run_op(rows[i].op, rows[i].m, rows[i].bs, rows[i].od, 8'h00, 8'h00);
      check(acc_a, rows[i].a);
      check(acc_b, rows[i].b);
      check(idx_x, rows[i].x);
      check({15'h0, carry}, {15'h0, rows[i].c});
    end
    check(idx_y, 16'h0abc);
    run_op(`CLSP_OP_PUSH_A, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h00);
    check({u_mem.mem[16'h01ff], u_mem.mem[16'h01fe]}, 16'h0ce0);
    run_op(`CLSP_OP_PUSH_B, 1'b1, 1'b0, 16'h0000, 8'h00, 8'h00);
    check({nw, u_mem.mem[16'h01fd]}, 16'h0101);
    check(sp, 16'h01fc);
    run_op(`CLSP_OP_PUSH_IMM, 1'b0, 1'b0, 16'h0000, 8'h11, 8'h22);
    check({u_mem.mem[16'h01fc], u_mem.mem[16'h01fb]}, 16'h2211);
    p = pc;
    run_op(`CLSP_OP_PUSH_REL, 1'b0, 1'b0, 16'h0000, 8'h11, 8'h22);
    check({u_mem.mem[16'h01fa], u_mem.mem[16'h01f9]}, p + 16'h2211);
    run_op(`CLSP_OP_PUSH_IND, 1'b0, 1'b0, 16'h0000, 8'h11, 8'h00);
    check({u_mem.mem[16'h01f8], u_mem.mem[16'h01f7]}, 16'h4d3c);
    check(sp, 16'h01f6);
    p = pc;
    run_op(`CLSP_OP_NOP, 1'b0, 1'b0, 16'hffff, 8'h00, 8'h00);
    check(pc, p + 16'h0001);
    check(acc_a, 16'h0ce0);
    check(sp, 16'h01f6);
    run_op(`CLSP_OP_LOAD_BNK, 1'b0, 1'b0, 16'h0000, 8'h7e, 8'h00);
    check({8'h00, data_bank}, 16'h007e);
    run_op(`CLSP_OP_LOAD_MEM, 1'b0, 1'b0, 16'h0000, 8'h9c, 8'h00);
    check({nw, u_mem.mem[16'h0200]}, 16'h019c);
    check(acc_a, 16'h0ce0);
    // shift a memory byte: result goes to the operand address, accumulators untouched
    @(posedge clk);
    to_mem <= 1'b1;
    run_op(`CLSP_OP_SHR, 1'b1, 1'b0, 16'h0081, 8'h00, 8'h00);
    check({7'h00, carry, u_mem.mem[16'h0200]}, 16'h0140);
    check(acc_a, 16'h0ce0);
    @(posedge clk);
    to_mem <= 1'b0;
    {mv_src, mv_dst, mv_cnt} <= {16'h0300, 16'h0400, 16'h0002};
    run_op(`CLSP_OP_MOVE_FWD, 1'b1, 1'b0, 16'h0000, 8'h00, 8'h00);
    check(fw, 16'h0400);
    check(lw, 16'h0402);
    check({u_mem.mem[16'h0402], u_mem.mem[16'h0400]}, 16'h0301);
    @(posedge clk);
    {mv_src, mv_dst, mv_cnt} <= {16'h0302, 16'h0502, 16'h0002};
    run_op(`CLSP_OP_MOVE_BWD, 1'b1, 1'b0, 16'h0000, 8'h00, 8'h00);
    check(fw, 16'h0502);
    check(lw, 16'h0500);
    check({u_mem.mem[16'h0502], u_mem.mem[16'h0500]}, 16'h0301);
    summarize;
  end
endmodule

// ===== bench/clsp_exec_checker.sv
`timescale 1ns/1ps
`include "clsp_defines.vh"
// operands are latched at the accepted start and judged when done pulses, or at each write strobe for pushes and each one after the first for moves
module clsp_exec_checker (
  input wire        clk,       // clock
  input wire        rstn,      // reset, active low
  input wire        start,     // start pulse
  input wire [3:0]  op_sel,    // operation
  input wire        m_flag,    // data width
  input wire        x_flag,    // index width
  input wire        acc_b_sel, // target b
  input wire        to_mem,    // shift to memory
  input wire [1:0]  instr_len, // length
  input wire [15:0] opnd,      // operand
  input wire        mem_wr,    // write strobe
  input wire [15:0] mem_addr,  // address
  input wire        busy,      // busy
  input wire        done,      // done pulse
  input wire [15:0] acc_a,     // acc a
  input wire [15:0] acc_b,     // acc b
  input wire [15:0] idx_x,     // index x
  input wire [15:0] pc,        // program counter
  input wire [15:0] sp,        // stack pointer
  input wire        carry      // carry
);
  reg [3:0]   op_r;
  reg         m_r, x_r, b_r, tm_r, ws_r;
  reg [1:0]   len_r;
  reg [15:0]  od_r, a_r, g_r, pc_r, wa_r;
  wire        take = start && !busy;
  wire [15:0] tgt = b_r ? acc_b : acc_a;
  // inputs may move after the start edge, so keep what the op began with
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {op_r, m_r, x_r, b_r, tm_r, ws_r, len_r} <= 11'h000;
      {od_r, a_r, g_r, pc_r, wa_r} <= 80'h0;
    end else if (take) begin
      {op_r, m_r, x_r, b_r, tm_r, ws_r} <= {op_sel, m_flag, x_flag, acc_b_sel, to_mem, 1'b0};
      {od_r, a_r, g_r, pc_r} <= {opnd, acc_a, acc_b_sel ? acc_b : acc_a, pc};
      len_r <= instr_len;
    end else if (mem_wr) begin
      ws_r <= 1'b1;
      wa_r <= mem_addr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_load_acc: assert property (
    done && op_r == `CLSP_OP_LOAD_ACC |-> tgt == (m_r ? {g_r[15:8], od_r[7:0]} : od_r))
    else $error("load result wrong");
  a_or_result: assert property (
    done && op_r == `CLSP_OP_OR |-> tgt == (m_r ? {g_r[15:8], g_r[7:0] | od_r[7:0]} : g_r | od_r))
    else $error("or result wrong");
  a_shr_result: assert property (
    done && op_r == `CLSP_OP_SHR && !tm_r |-> carry == g_r[0] &&
    tgt == (m_r ? {g_r[15:8], 1'b0, g_r[7:1]} : {1'b0, g_r[15:1]}))
    else $error("shift result wrong");
  a_mul_split: assert property (
    done && op_r == `CLSP_OP_MUL && !m_r |-> {acc_b, acc_a} == a_r * od_r)
    else $error("product halves wrong");
  a_mul_byte: assert property (
    done && op_r == `CLSP_OP_MUL && m_r |-> {acc_b[7:0], acc_a[7:0]} == {8'h00, a_r[7:0]} * {8'h00, od_r[7:0]})
    else $error("byte product halves wrong");
  a_idx_load: assert property (
    done && op_r == `CLSP_OP_LOAD_X && !x_r |-> idx_x == od_r)
    else $error("index load wrong");
  a_nop_keep: assert property (
    done && op_r == `CLSP_OP_NOP |-> pc == pc_r + {14'h0, len_r} && acc_a == a_r)
    else $error("nop changed state");
  a_push_sp: assert property (
    mem_wr && op_r >= `CLSP_OP_PUSH_IMM |-> mem_addr == sp + 16'h0001)
    else $error("push address not at stack");
  a_move_up: assert property (
    mem_wr && ws_r && op_r == `CLSP_OP_MOVE_FWD |-> mem_addr == wa_r + 16'h0001)
    else $error("forward move not ascending");
  a_move_down: assert property (
    mem_wr && ws_r && op_r == `CLSP_OP_MOVE_BWD |-> mem_addr == wa_r - 16'h0001)
    else $error("backward move not descending");
endmodule
bind clsp_exec clsp_exec_checker u_chk (
  .clk(clk), .rstn(rstn), .start(start), .op_sel(op_sel), .m_flag(m_flag), .x_flag(x_flag),
  .acc_b_sel(acc_b_sel), .to_mem(to_mem), .instr_len(instr_len), .opnd(opnd), .mem_wr(mem_wr),
  .mem_addr(mem_addr), .busy(busy), .done(done), .acc_a(acc_a), .acc_b(acc_b), .idx_x(idx_x),
  .pc(pc), .sp(sp), .carry(carry));

// ===== bench/clsp_mem_model.sv
`timescale 1ns/1ps
// byte memory for operands and stack; read data only valid the cycle after a read strobe
module clsp_mem_model (
  input  wire        clk,      // clock
  input  wire        clr,      // clear write log
  input  wire        rd,       // read strobe
  input  wire        wr,       // write strobe
  input  wire [15:0] addr,     // address
  input  wire [7:0]  wdata,    // write data
  output reg  [7:0]  rdata,    // read data
  output reg  [15:0] first_wr, // first write address
  output reg  [15:0] last_wr,  // last write address
  output reg  [7:0]  n_wr      // writes since clear
);
  reg [7:0] mem [0:65535];
  integer   i;
  initial begin
    for (i = 0; i < 65536; i = i + 1) mem[i] = 8'ha5;
    rdata = 8'h5a;
    first_wr = 16'h0000;
    last_wr = 16'h0000;
    n_wr = 8'h00;
  end
  // stale read data flips each cycle so a late sample never passes by luck
  always @(posedge clk) begin
    rdata <= rd ? mem[addr] : ~rdata;
    if (clr) begin
      n_wr <= 8'h00;
    end else if (wr) begin
      mem[addr] <= wdata;
      if (n_wr == 8'h00) first_wr <= addr;
      last_wr <= addr;
      n_wr <= n_wr + 8'h01;
    end
  end
endmodule

// ===== design/clsp_alu.v
`timescale 1ns/1ps
`include "clsp_defines.vh"
// combinational datapath: or, shift right, multiply
module clsp_alu (
  input  wire [3:0]  op,       // operation select
  input  wire        m_flag,   // 1 = byte width
  input  wire [15:0] acc,      // accumulator operand
  input  wire [15:0] opnd,     // memory operand
  output reg  [15:0] res_lo,   // result or low product
  output reg  [15:0] res_hi,   // upper product half
  output reg         carry     // carry out of shift
);
  reg [31:0] prod;
  // byte mode of shift and multiply keeps only the low lane so the top bits of a short operand stay out
  always @* begin
    prod   = acc * opnd;
    res_lo = acc;
    res_hi = `CLSP_RST_WORD;
    carry  = 1'b0;
    case (op)
      `CLSP_OP_OR: begin
        res_lo = acc | opnd;
      end
      `CLSP_OP_SHR: begin
        carry  = opnd[0];
        res_lo = {1'b0, opnd[`CLSP_WORD_MSB:1]};
        if (m_flag) begin
          res_lo = {8'h00, 1'b0, opnd[`CLSP_BYTE_MSB:1]};
        end
      end
      `CLSP_OP_MUL: begin
        if (m_flag) begin
          // widen both bytes first: a bare byte product would lose its top half
          prod   = {16'h0000, {8'h00, acc[`CLSP_BYTE_MSB:0]} * {8'h00, opnd[`CLSP_BYTE_MSB:0]}};
          res_lo = {8'h00, prod[`CLSP_BYTE_MSB:0]};
          res_hi = {8'h00, prod[15:8]};
        end else begin
          res_lo = prod[15:0];
          res_hi = prod[31:16];
        end
      end
      default: begin
        res_lo = opnd;
      end
    endcase
  end
endmodule

// ===== design/clsp_exec.v
`timescale 1ns/1ps
`include "clsp_defines.vh"
module clsp_exec (
  input  wire        clk,        // 10 mhz clock
  input  wire        rstn,       // async reset, active low
  input  wire        start,      // pulse: execute op_sel
  input  wire [3:0]  op_sel,     // decoded operation
  input  wire        m_flag,     // data width flag
  input  wire        x_flag,     // index width flag
  input  wire        acc_b_sel,  // 1 = target accumulator b
  input  wire        to_mem,     // shift result goes to memory
  input  wire [7:0]  imm1,       // second instruction byte
  input  wire [7:0]  imm2,       // third instruction byte
  input  wire [1:0]  instr_len,  // instruction length in bytes
  input  wire [15:0] opnd,       // memory operand, already fetched
  input  wire [15:0] ea,         // effective operand address
  input  wire [15:0] mv_src,     // block move source start
  input  wire [15:0] mv_dst,     // block move destination start
  input  wire [15:0] mv_cnt,     // block move byte count minus one
  input  wire [15:0] direct_page_register,        // direct_page_register value
  input  wire [7:0]  mem_rdata,  // memory read data, valid a cycle after mem_rd
  output reg         mem_rd,     // memory read strobe
  output reg         mem_wr,     // memory write strobe
  output reg  [15:0] mem_addr,   // memory address
  output reg  [7:0]  mem_wdata,  // memory write data
  output wire        busy,       // operation in progress
  output reg         done,       // pulse: operation finished
  output reg  [15:0] acc_a,      // accumulator a
  output reg  [15:0] acc_b,      // accumulator b
  output reg  [15:0] idx_x,      // index register x
  output reg  [15:0] idx_y,      // index register y
  output reg  [7:0]  data_bank,  // data_bank_register
  output reg  [15:0] pc,         // program counter
  output reg  [15:0] sp,         // stack pointer
  output reg         carry       // carry flag
);
  localparam S_IDLE  = 5'h01;
  localparam S_PUSH  = 5'h02;
  localparam S_RD    = 5'h04;
  localparam S_MVRD  = 5'h08;
  localparam S_MVWR  = 5'h10;

  reg [4:0]  state_r;
  reg [3:0]  op_r;
  reg [7:0]  pbuf_r [0:1];      // bytes queued for the stack, index 0 first
  reg [1:0]  pcnt_r;            // bytes left to push
  reg        pidx_r;            // next pbuf entry
  reg        rdidx_r;           // push indirect read phase
  reg        rdwait_r;          // read data arrives next cycle
  reg [15:0] src_r;
  reg [15:0] dst_r;
  reg [15:0] cnt_r;
  reg        dir_r;             // 1 = backward move
  reg [7:0]  mvbyte_r;

  wire [15:0] alu_lo;
  wire [15:0] alu_hi;
  wire        alu_c;
  wire [15:0] acc_sel = acc_b_sel ? acc_b : acc_a;
  wire [15:0] rel_sum = pc + {imm2, imm1};
  // the push opcode alone picks the source, the target select plays no part
  wire [15:0] push_src = (op_sel == `CLSP_OP_PUSH_B) ? acc_b : acc_a;

  clsp_alu u_alu (
    .op     (op_sel),
    .m_flag (m_flag),
    .acc    (op_sel == `CLSP_OP_MUL ? acc_a : acc_sel),
    .opnd   (op_sel == `CLSP_OP_SHR && !to_mem ? acc_sel : opnd),
    .res_lo (alu_lo),
    .res_hi (alu_hi),
    .carry  (alu_c)
  );

  assign busy = (state_r != S_IDLE);

  // merge a byte-wide result into a word, top byte kept in byte mode
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input        narrow;
    begin
      merge = narrow ? {old[15:8], nw[`CLSP_BYTE_MSB:0]} : nw;
    end
  endfunction

  // program counter step past the instruction
  function [15:0] pc_step;
    input [15:0] p;
    input [1:0]  len;
    begin
      pc_step = p + {14'h0000, len};
    end
  endfunction

  // main sequencer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= S_IDLE;
      op_r      <= `CLSP_OP_NOP;
      pbuf_r[0] <= `CLSP_RST_BYTE;
      pbuf_r[1] <= `CLSP_RST_BYTE;
      pcnt_r    <= 2'h0;
      pidx_r    <= 1'b0;
      rdidx_r   <= 1'b0;
      rdwait_r  <= 1'b0;
      src_r     <= `CLSP_RST_WORD;
      dst_r     <= `CLSP_RST_WORD;
      cnt_r     <= `CLSP_RST_WORD;
      dir_r     <= 1'b0;
      mvbyte_r  <= `CLSP_RST_BYTE;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= `CLSP_RST_WORD;
      mem_wdata <= `CLSP_RST_BYTE;
      done      <= 1'b0;
      acc_a     <= `CLSP_RST_WORD;
      acc_b     <= `CLSP_RST_WORD;
      idx_x     <= `CLSP_RST_WORD;
      idx_y     <= `CLSP_RST_WORD;
      data_bank <= `CLSP_RST_BYTE;
      pc        <= `CLSP_RST_WORD;
      sp        <= `CLSP_RST_SP;
      carry     <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      done   <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r <= op_sel;
            pc   <= pc_step(pc, instr_len);
            case (op_sel)
              `CLSP_OP_NOP: begin
                done <= 1'b1;
              end
              `CLSP_OP_LOAD_ACC, `CLSP_OP_OR: begin
                if (acc_b_sel) begin
                  acc_b <= merge(acc_b, alu_lo, m_flag);
                end else begin
                  acc_a <= merge(acc_a, alu_lo, m_flag);
                end
                done <= 1'b1;
              end
              `CLSP_OP_LOAD_MEM: begin
                mem_wr    <= 1'b1;
                mem_addr  <= ea;
                mem_wdata <= imm1;
                done      <= 1'b1;
              end
              `CLSP_OP_LOAD_BNK: begin
                data_bank <= imm1;
                done      <= 1'b1;
              end
              `CLSP_OP_LOAD_X: begin
                idx_x <= merge(idx_x, opnd, x_flag);
                done  <= 1'b1;
              end
              `CLSP_OP_LOAD_Y: begin
                idx_y <= merge(idx_y, opnd, x_flag);
                done  <= 1'b1;
              end
              `CLSP_OP_SHR: begin
                carry <= alu_c;
                if (to_mem) begin
                  mem_wr    <= 1'b1;
                  mem_addr  <= ea;
                  mem_wdata <= alu_lo[`CLSP_BYTE_MSB:0];
                end else if (acc_b_sel) begin
                  acc_b <= merge(acc_b, alu_lo, m_flag);
                end else begin
                  acc_a <= merge(acc_a, alu_lo, m_flag);
                end
                done <= 1'b1;
              end
              `CLSP_OP_MUL: begin
                acc_a <= merge(acc_a, alu_lo, m_flag);
                acc_b <= merge(acc_b, alu_hi, m_flag);
                done  <= 1'b1;
              end
              `CLSP_OP_MOVE_FWD, `CLSP_OP_MOVE_BWD: begin
                dir_r   <= (op_sel == `CLSP_OP_MOVE_BWD);
                src_r   <= mv_src;
                dst_r   <= mv_dst;
                cnt_r   <= mv_cnt;
                mem_rd  <= 1'b1;
                mem_addr <= mv_src;
                rdidx_r <= 1'b1;
                rdwait_r <= 1'b1;
                state_r <= S_MVRD;
              end
              `CLSP_OP_PUSH_IMM: begin
                pbuf_r[0] <= imm2;
                pbuf_r[1] <= imm1;
                pcnt_r    <= 2'h2;
                pidx_r    <= 1'b0;
                state_r   <= S_PUSH;
              end
              `CLSP_OP_PUSH_IND: begin
                mem_rd   <= 1'b1;
                mem_addr <= direct_page_register + {8'h00, imm1} + 16'h0001;
                rdidx_r  <= 1'b0;
                rdwait_r <= 1'b1;
                state_r  <= S_RD;
              end
              `CLSP_OP_PUSH_REL: begin
                pbuf_r[0] <= rel_sum[15:8];
                pbuf_r[1] <= rel_sum[`CLSP_BYTE_MSB:0];
                pcnt_r    <= 2'h2;
                pidx_r    <= 1'b0;
                state_r   <= S_PUSH;
              end
              default: begin
                // push a or b: high byte only in word mode
                pbuf_r[0] <= m_flag ? push_src[7:0] : push_src[15:8];
                pbuf_r[1] <= push_src[`CLSP_BYTE_MSB:0];
                pcnt_r    <= m_flag ? 2'h1 : 2'h2;
                pidx_r    <= 1'b0;
                state_r   <= S_PUSH;
              end
            endcase
          end
        end
        S_PUSH: begin
          // one byte per cycle at sp, then sp steps down
          mem_wr    <= 1'b1;
          mem_addr  <= sp;
          mem_wdata <= pbuf_r[pidx_r];
          sp        <= sp - 16'h0001;
          pidx_r    <= 1'b1;
          pcnt_r    <= pcnt_r - 2'h1;
          if (pcnt_r == 2'h1) begin
            done    <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_RD: begin
          // the high byte comes first so it lands on the stack first
          if (rdwait_r) begin
            rdwait_r <= 1'b0;
          end else if (!rdidx_r) begin
            pbuf_r[0] <= mem_rdata;
            mem_rd    <= 1'b1;
            mem_addr  <= direct_page_register + {8'h00, imm1};
            rdidx_r   <= 1'b1;
            rdwait_r  <= 1'b1;
          end else begin
            pbuf_r[1] <= mem_rdata;
            pcnt_r    <= 2'h2;
            pidx_r    <= 1'b0;
            state_r   <= S_PUSH;
          end
        end
        S_MVRD: begin
          // issue, wait one cycle for the memory, then take the byte; the address bus carries src_r for the read
          if (!rdidx_r) begin
            mem_rd   <= 1'b1;
            mem_addr <= src_r;
            rdidx_r  <= 1'b1;
            rdwait_r <= 1'b1;
          end else if (rdwait_r) begin
            rdwait_r <= 1'b0;
          end else begin
            mvbyte_r <= mem_rdata;
            rdidx_r  <= 1'b0;
            state_r  <= S_MVWR;
          end
        end
        S_MVWR: begin
          mem_wr    <= 1'b1;
          mem_addr  <= dst_r;
          mem_wdata <= mvbyte_r;
          src_r     <= dir_r ? src_r - 16'h0001 : src_r + 16'h0001;
          dst_r     <= dir_r ? dst_r - 16'h0001 : dst_r + 16'h0001;
          cnt_r     <= cnt_r - 16'h0001;
          if (cnt_r == `CLSP_RST_WORD) begin
            done    <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            state_r <= S_MVRD;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== pkg/clsp_defines.vh
`ifndef CLSP_DEFINES_VH
`define CLSP_DEFINES_VH
// operation select codes on op_sel
`define CLSP_OP_NOP      4'h0
`define CLSP_OP_LOAD_ACC 4'h1
`define CLSP_OP_LOAD_MEM 4'h2
`define CLSP_OP_LOAD_BNK 4'h3
`define CLSP_OP_LOAD_X   4'h4
`define CLSP_OP_LOAD_Y   4'h5
`define CLSP_OP_SHR      4'h6
`define CLSP_OP_MUL      4'h7
`define CLSP_OP_MOVE_FWD 4'h8
`define CLSP_OP_MOVE_BWD 4'h9
`define CLSP_OP_OR       4'ha
`define CLSP_OP_PUSH_IMM 4'hb
`define CLSP_OP_PUSH_IND 4'hc
`define CLSP_OP_PUSH_REL 4'hd
`define CLSP_OP_PUSH_A   4'he
`define CLSP_OP_PUSH_B   4'hf
// opcode values and lengths carried through for the decoder side
`define CLSP_OPC_NOP     8'hea
`define CLSP_OPC_LDX_IMM 8'ha2
`define CLSP_OPC_LDY_IMM 8'ha0
`define CLSP_OPC_LDT_PRE 8'h89
`define CLSP_OPC_LDT_2ND 8'hc2
`define CLSP_LEN_NOP     2'h1
`define CLSP_LEN_IDX_IMM 2'h2
`define CLSP_LEN_LDT     2'h3
// bit positions
`define CLSP_MSB_WORD    4
`define CLSP_BYTE_MSB    7
`define CLSP_WORD_MSB    15
// reset values
`define CLSP_RST_WORD    16'h0000
`define CLSP_RST_BYTE    8'h00
`define CLSP_RST_SP      16'h01ff
`endif
